/* logic/adcctl_bcdiv.sv */
// Basic clock divider: one tick per basic clock period.
// Assumes sys_tick_i marks each system clock period.
`timescale 1ns/100ps

module adcctl_bcdiv (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic sys_tick_i,
   input wire logic improved_mode_i,
   input wire logic [1:0] divider_select_i,
   input wire logic [7:0] improved_divider_i,
   output logic bc_tick_o
);

   logic [8:0] cnt;
   logic [8:0] divisor;

   // Improved mode divides by field plus one; otherwise the fixed table
   always_comb begin
      if (improved_mode_i) begin
         divisor = {1'b0, improved_divider_i} + adcctl_pkg::BC_DIV_ONE;
      end else begin
         divisor = adcctl_pkg::bc_divisor(divider_select_i);
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt <= 9'h000;
         bc_tick_o <= 1'b0;
      end else begin
         bc_tick_o <= 1'b0;
         if (sys_tick_i) begin
            if (cnt >= divisor - adcctl_pkg::BC_DIV_ONE) begin
               cnt <= 9'h000;
               bc_tick_o <= 1'b1;
            end else begin
               cnt <= cnt + 9'h001;
            end
         end
      end
   end

   div_ratio_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (!improved_mode_i && divider_select_i == 2'h1 && $stable(divider_select_i)
       && $stable(improved_mode_i) && sys_tick_i && cnt == 9'h001)
      |=> bc_tick_o)
      else $error("divide-by-two basic clock missed its tick");

endmodule

/* logic/adcctl_pkg.sv */
// Constants, state type and decode functions for the converter timing control.
// Assumes one clock; all counts are in ticks of the system or basic clock.
package adcctl_pkg;

   // ------------------------------------------------------------
   // Basic clock divider codes (compatibility mode)
   // ------------------------------------------------------------
   localparam logic [8:0] BC_DIV_CODE0 = 9'h004;
   localparam logic [8:0] BC_DIV_CODE1 = 9'h002;
   localparam logic [8:0] BC_DIV_CODE2 = 9'h010;
   localparam logic [8:0] BC_DIV_CODE3 = 9'h008;
   localparam logic [8:0] BC_DIV_ONE = 9'h001;

   // ------------------------------------------------------------
   // Phase lengths in basic clock periods
   // ------------------------------------------------------------
   localparam logic [7:0] SAMPLE_LEN_CODE0 = 8'h08;
   localparam logic [7:0] SAMPLE_LEN_CODE1 = 8'h10;
   localparam logic [7:0] SAMPLE_LEN_CODE2 = 8'h20;
   localparam logic [7:0] SAMPLE_LEN_CODE3 = 8'h40;
   localparam logic [7:0] BITS_LEN_10 = 8'h28;
   localparam logic [7:0] BITS_LEN_8 = 8'h20;
   localparam logic [7:0] POSTCAL_LEN = 8'h0c;

   // ------------------------------------------------------------
   // Result load, calibration, result codes and master clock mode reset value
   // ------------------------------------------------------------
   localparam logic [2:0] LOAD_SYS_LEN = 3'h6;
   localparam int CAL_MIN_BC = 484;
   localparam int CAL_MAX_BC = 11696;
   localparam int CAL_CNT_W = 14;
   localparam logic [9:0] CODE_ZERO = 10'h000;
   localparam logic [9:0] CODE_FULL = 10'h3ff;
   localparam logic [1:0] MODE_RESET = 2'h0;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SAMPLE,
      ST_BITS,
      ST_POSTCAL,
      ST_LOAD
   } adcctl_state_type;

   function automatic logic [8:0] bc_divisor(input logic [1:0] sel);
      logic [8:0] d;
      d = BC_DIV_CODE0;
      unique case (sel)
         2'h0: d = BC_DIV_CODE0;
         2'h1: d = BC_DIV_CODE1;
         2'h2: d = BC_DIV_CODE2;
         2'h3: d = BC_DIV_CODE3;
      endcase
      return d;
   endfunction

   function automatic logic [7:0] sample_len(input logic [1:0] sel);
      logic [7:0] n;
      n = SAMPLE_LEN_CODE0;
      unique case (sel)
         2'h0: n = SAMPLE_LEN_CODE0;
         2'h1: n = SAMPLE_LEN_CODE1;
         2'h2: n = SAMPLE_LEN_CODE2;
         2'h3: n = SAMPLE_LEN_CODE3;
      endcase
      return n;
   endfunction

endpackage

/* logic/adcctl_sysclk.sv */
// System clock tick generator and master clock mechanism latch.
// Assumes clk_i is the master clock; the system clock equals the CPU clock.
`timescale 1ns/100ps

module adcctl_sysclk (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic cpu_clock_halving_select_i,
   input wire logic [1:0] master_clock_source_control_i,
   output logic sys_tick_o,
   output logic [1:0] master_clock_mode_o
);

   logic phase;

   // ------------------------------------------------------------
   // CPU / system clock tick
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         phase <= 1'b0;
         sys_tick_o <= 1'b0;
      end else begin
         phase <= ~phase;
         // One tick serves both CPU and peripherals, so they never differ
         sys_tick_o <= ~cpu_clock_halving_select_i | phase;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         master_clock_mode_o <= adcctl_pkg::MODE_RESET;
      end else begin
         master_clock_mode_o <= master_clock_source_control_i;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   halved_rate_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (cpu_clock_halving_select_i && $past(cpu_clock_halving_select_i) && sys_tick_o)
      |=> !sys_tick_o)
      else $error("halved system clock ticked twice in a row");

   mode_follow_a: assert property (@(posedge clk_i) disable iff (reset_i)
      $stable(master_clock_source_control_i) |=>
      master_clock_mode_o == $past(master_clock_source_control_i))
      else $error("master clock mode not taken from control");

endmodule

/* logic/adcctl_top.sv */
// Conversion timing and sequencing control for the successive-approximation
// converter. Assumes synchronous inputs and software-valid control fields.
`timescale 1ns/100ps

module adcctl_top #(
   parameter int CAL_MAX = adcctl_pkg::CAL_MAX_BC
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic start_i,
   input wire logic resolution_8bit_i,
   input wire logic post_cal_enable_i,
   input wire logic improved_mode_i,
   input wire logic [1:0] basic_clock_divider_select_i,
   input wire logic [1:0] sample_time_select_i,
   input wire logic [7:0] improved_divider_i,
   input wire logic cpu_clock_halving_select_i,
   input wire logic [1:0] master_clock_source_control_i,
   input wire logic signed [11:0] analog_sample_i,
   input wire logic ref_settled_i,
   output logic busy_o,
   output logic calibrating_o,
   output logic [9:0] result_o,
   output logic result_valid_o,
   output logic sys_tick_o,
   output logic basic_clock_tick_o,
   output logic [1:0] master_clock_mode_o
);

   localparam int CAL_W = adcctl_pkg::CAL_CNT_W;
   localparam logic [CAL_W-1:0] CAL_MIN_LAST = CAL_W'(adcctl_pkg::CAL_MIN_BC - 1);
   localparam logic [CAL_W-1:0] CAL_MAX_LAST = CAL_W'(CAL_MAX - 1);

   adcctl_pkg::adcctl_state_type state;
   adcctl_pkg::adcctl_state_type next_state;
   logic [7:0] cnt;
   logic [2:0] load_cnt;
   logic [7:0] len_sample;
   logic res8;
   logic postcal;
   logic [9:0] held_code;
   logic held_low;
   logic held_high;
   logic [CAL_W-1:0] cal_cnt;
   logic phase_last;

   // ------------------------------------------------------------
   // Clock generation
   // ------------------------------------------------------------
   adcctl_sysclk u_sysclk (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .cpu_clock_halving_select_i(cpu_clock_halving_select_i),
      .master_clock_source_control_i(master_clock_source_control_i),
      .sys_tick_o(sys_tick_o),
      .master_clock_mode_o(master_clock_mode_o)
   );

   adcctl_bcdiv u_bcdiv (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .sys_tick_i(sys_tick_o),
      .improved_mode_i(improved_mode_i),
      .divider_select_i(basic_clock_divider_select_i),
      .improved_divider_i(improved_divider_i),
      .bc_tick_o(basic_clock_tick_o)
   );

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb begin
      phase_last = 1'b0;
      unique case (state)
         // First basic tick opens the sample, so it spans whole basic periods
         adcctl_pkg::ST_SAMPLE: phase_last = (cnt == len_sample);
         adcctl_pkg::ST_BITS: begin
            if (res8) begin
               phase_last = (cnt == adcctl_pkg::BITS_LEN_8 - 8'h01);
            end else begin
               phase_last = (cnt == adcctl_pkg::BITS_LEN_10 - 8'h01);
            end
         end
         adcctl_pkg::ST_POSTCAL: phase_last = (cnt == adcctl_pkg::POSTCAL_LEN - 8'h01);
         default: phase_last = 1'b0;
      endcase
   end

   always_comb begin
      next_state = state;
      unique case (state)
         adcctl_pkg::ST_IDLE: begin
            if (start_i) begin
               next_state = adcctl_pkg::ST_SAMPLE;
            end
         end
         adcctl_pkg::ST_SAMPLE: begin
            if (basic_clock_tick_o && phase_last) begin
               next_state = adcctl_pkg::ST_BITS;
            end
         end
         adcctl_pkg::ST_BITS: begin
            if (basic_clock_tick_o && phase_last) begin
               // Skipping post-calibration removes its 12 basic clocks
               next_state = postcal ? adcctl_pkg::ST_POSTCAL : adcctl_pkg::ST_LOAD;
            end
         end
         adcctl_pkg::ST_POSTCAL: begin
            if (basic_clock_tick_o && phase_last) begin
               next_state = adcctl_pkg::ST_LOAD;
            end
         end
         adcctl_pkg::ST_LOAD: begin
            if (sys_tick_o && load_cnt == adcctl_pkg::LOAD_SYS_LEN - 3'h1) begin
               next_state = adcctl_pkg::ST_IDLE;
            end
         end
         default: next_state = adcctl_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state <= adcctl_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Phase counters restart on every state change
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt <= 8'h00;
         load_cnt <= 3'h0;
      end else if (next_state != state) begin
         cnt <= 8'h00;
         load_cnt <= 3'h0;
      end else begin
         if (basic_clock_tick_o) begin
            cnt <= cnt + 8'h01;
         end
         if (state == adcctl_pkg::ST_LOAD && sys_tick_o) begin
            load_cnt <= load_cnt + 3'h1;
         end
      end
   end

   // Sample time, resolution and post-calibration settings are frozen for the whole conversion
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         len_sample <= adcctl_pkg::SAMPLE_LEN_CODE0;
         res8 <= 1'b0;
         postcal <= 1'b1;
      end else if (state == adcctl_pkg::ST_IDLE && start_i) begin
         len_sample <= adcctl_pkg::sample_len(sample_time_select_i);
         res8 <= resolution_8bit_i;
         postcal <= post_cal_enable_i;
      end
   end

   // ------------------------------------------------------------
   // Sampled value and saturation
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         held_code <= adcctl_pkg::CODE_ZERO;
         held_low <= 1'b0;
         held_high <= 1'b0;
      end else if (state == adcctl_pkg::ST_SAMPLE && next_state == adcctl_pkg::ST_BITS) begin
         held_low <= analog_sample_i < 12'sh000;
         held_high <= analog_sample_i > 12'sh3ff;
         if (analog_sample_i < 12'sh000) begin
            held_code <= adcctl_pkg::CODE_ZERO;
         end else if (analog_sample_i > 12'sh3ff) begin
            held_code <= adcctl_pkg::CODE_FULL;
         end else begin
            held_code <= analog_sample_i[9:0];
         end
      end
   end

   // 8-bit results sit left-aligned with the two low bits cleared
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         result_o <= adcctl_pkg::CODE_ZERO;
         result_valid_o <= 1'b0;
      end else begin
         result_valid_o <= 1'b0;
         if (state == adcctl_pkg::ST_LOAD && next_state == adcctl_pkg::ST_IDLE) begin
            result_o <= res8 ? {held_code[9:2], 2'b00} : held_code;
            result_valid_o <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         busy_o <= 1'b0;
      end else begin
         busy_o <= next_state != adcctl_pkg::ST_IDLE;
      end
   end

   // ------------------------------------------------------------
   // Reset calibration
   // ------------------------------------------------------------
   // Counts only while idle, so each conversion lengthens it
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         calibrating_o <= 1'b1;
         cal_cnt <= '0;
      end else if (calibrating_o && basic_clock_tick_o
                   && state == adcctl_pkg::ST_IDLE) begin
         if ((cal_cnt >= CAL_MIN_LAST && ref_settled_i) || cal_cnt >= CAL_MAX_LAST) begin
            calibrating_o <= 1'b0;
         end else begin
            cal_cnt <= cal_cnt + CAL_W'(1);
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sample_length_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (state == adcctl_pkg::ST_SAMPLE && next_state == adcctl_pkg::ST_BITS)
      |-> (cnt == len_sample && basic_clock_tick_o))
      else $error("sample phase ended at wrong length");

   bits_ten_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (state == adcctl_pkg::ST_BITS && next_state != state && !res8)
      |-> cnt == 8'h27)
      else $error("10-bit determination length wrong");

   bits_eight_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (state == adcctl_pkg::ST_BITS && next_state != state && res8)
      |-> cnt == 8'h1f)
      else $error("8-bit determination length wrong");

   postcal_skip_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (state == adcctl_pkg::ST_BITS && next_state != state)
      |=> (state == (postcal ? adcctl_pkg::ST_POSTCAL : adcctl_pkg::ST_LOAD)))
      else $error("post-calibration phase taken against setting");

   load_length_a: assert property (@(posedge clk_i) disable iff (reset_i)
      result_valid_o |-> ($past(state) == adcctl_pkg::ST_LOAD && $past(load_cnt) == 3'h5
                          && $past(sys_tick_o)))
      else $error("result loaded before six system clocks");

   cal_minimum_a: assert property (@(posedge clk_i) disable iff (reset_i)
      $fell(calibrating_o) |-> $past(cal_cnt) >= CAL_MIN_LAST)
      else $error("calibration ended too early");

   cal_pause_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (calibrating_o && state != adcctl_pkg::ST_IDLE) |=> $stable(cal_cnt))
      else $error("calibration advanced during a conversion");

   sat_low_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (result_valid_o && held_low) |-> result_o == adcctl_pkg::CODE_ZERO)
      else $error("underrange input not clamped to zero");

   sat_high_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (result_valid_o && held_high && !res8) |-> result_o == adcctl_pkg::CODE_FULL)
      else $error("overrange input not clamped to full scale");

   phase_order_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (state == adcctl_pkg::ST_IDLE) |=> (state == adcctl_pkg::ST_IDLE
                                         || state == adcctl_pkg::ST_SAMPLE))
      else $error("conversion began outside the sample phase");

   postcal_length_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (state == adcctl_pkg::ST_POSTCAL && next_state != state)
      |-> cnt == adcctl_pkg::POSTCAL_LEN - 8'h01)
      else $error("post-calibration phase length wrong");

   busy_start_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (state == adcctl_pkg::ST_IDLE && start_i)
      |=> (busy_o && state == adcctl_pkg::ST_SAMPLE))
      else $error("accepted start did not open the sample phase");

   cal_maximum_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (calibrating_o && basic_clock_tick_o && state == adcctl_pkg::ST_IDLE
       && cal_cnt >= CAL_MAX_LAST) |=> !calibrating_o)
      else $error("calibration ran past its maximum");

   result_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
      !result_valid_o |-> $stable(result_o))
      else $error("result changed without a valid pulse");

   settings_frozen_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (state != adcctl_pkg::ST_IDLE)
      |=> ($stable(len_sample) && $stable(res8) && $stable(postcal)))
      else $error("conversion settings changed mid conversion");

endmodule

/* testbench/adcctl_sw_model.sv */
// Software-side model: writes the clock control fields of the converter.
// Assumes a 100 MHz master clock and requests that change at the falling edge.
`timescale 1ns/100ps

module adcctl_sw_model (
   input wire logic permit_fast_i,
   input wire logic halve_i,
   input wire logic [1:0] div_sel_i,
   input wire logic [1:0] src_i,
   output logic cpu_clock_halving_select_o,
   output logic [1:0] basic_clock_divider_select_o,
   output logic [1:0] master_clock_source_control_o
);
   // ------------------------------------------------------------
   // Basic clock rate guard
   // ------------------------------------------------------------
   logic [5:0] prod;

   // Master ticks per basic tick; below 5 the basic clock passes 20 MHz
   always_comb begin
      prod = 6'h08;
      case (div_sel_i)
         2'h0: prod = 6'h04;
         2'h1: prod = 6'h02;
         2'h2: prod = 6'h10;
         default: prod = 6'h08;
      endcase
      if (halve_i) begin
         prod = prod << 1;
      end
   end

   // Only a scenario that asks for it may overclock the converter
   always_comb begin
      basic_clock_divider_select_o = div_sel_i;
      if (prod < 6'h05 && !permit_fast_i) begin
         basic_clock_divider_select_o = 2'h3;
      end
   end

   assign cpu_clock_halving_select_o = halve_i;
   assign master_clock_source_control_o = src_i;
endmodule

/* testbench/test_adc_conversion_timing_control.sv */
// Self-checking bench for the converter timing control.
// Assumes the software model drives the clock fields; inputs move at falling edges.
`timescale 1ns/100ps

module test_adc_conversion_timing_control;
   localparam int CAL_SIM = 600;
   typedef struct {
      logic halve;
      logic [1:0] dsel;
      logic imp;
      logic [7:0] idiv;
      logic [1:0] ssel;
      logic r8;
      logic pc;
      logic [11:0] ain;
      logic [9:0] res;
   } adcctl_row_type;

   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic start = 1'b0;
   logic res8 = 1'b0;
   logic pcal = 1'b0;
   logic imp = 1'b0;
   logic halve = 1'b0;
   logic settled = 1'b1;
   logic [1:0] dsel = 2'h1;
   logic [1:0] ssel = 2'h0;
   logic [1:0] src = 2'h0;
   logic [7:0] idiv = 8'h00;
   logic signed [11:0] ain = 12'h000;
   logic cpu_half, busy, calib, valid, sys_tick, bc_tick;
   logic [1:0] div_w, src_w, mode;
   logic [9:0] result;
   int error_cnt = 0;
   int cmp_count = 0;
   int n, m, d, p, lo;
   int div_tab [4] = '{4, 2, 16, 8};
   int smp_tab [4] = '{8, 16, 32, 64};
   adcctl_row_type rows [7] = '{
      '{1'b0, 2'h1, 1'b0, 8'h00, 2'h0, 1'b0, 1'b1, 12'h12c, 10'h12c},
      '{1'b0, 2'h0, 1'b0, 8'h00, 2'h1, 1'b0, 1'b0, 12'hffb, 10'h000},
      '{1'b1, 2'h3, 1'b0, 8'h00, 2'h2, 1'b1, 1'b1, 12'h7d0, 10'h3fc},
      '{1'b0, 2'h2, 1'b0, 8'h00, 2'h3, 1'b1, 1'b0, 12'h12d, 10'h12c},
      '{1'b0, 2'h1, 1'b1, 8'h02, 2'h0, 1'b0, 1'b0, 12'h3ff, 10'h3ff},
      '{1'b1, 2'h1, 1'b0, 8'h00, 2'h0, 1'b0, 1'b1, 12'h5dc, 10'h3ff},
      '{1'b0, 2'h1, 1'b0, 8'h00, 2'h1, 1'b1, 1'b1, 12'h000, 10'h000}};

   always #5 clk_i = ~clk_i;

   // Overclocking is allowed here to keep the run short
   adcctl_sw_model sw_u (.permit_fast_i(1'b1), .halve_i(halve), .div_sel_i(dsel),
      .src_i(src), .cpu_clock_halving_select_o(cpu_half),
      .basic_clock_divider_select_o(div_w), .master_clock_source_control_o(src_w));

   adcctl_top #(.CAL_MAX(CAL_SIM)) dut_u (.clk_i(clk_i), .reset_i(reset_i), .start_i(start),
      .resolution_8bit_i(res8), .post_cal_enable_i(pcal), .improved_mode_i(imp),
      .basic_clock_divider_select_i(div_w), .sample_time_select_i(ssel),
      .improved_divider_i(idiv), .cpu_clock_halving_select_i(cpu_half),
      .master_clock_source_control_i(src_w), .analog_sample_i(ain),
      .ref_settled_i(settled), .busy_o(busy), .calibrating_o(calib), .result_o(result),
      .result_valid_o(valid), .sys_tick_o(sys_tick), .basic_clock_tick_o(bc_tick),
      .master_clock_mode_o(mode));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      $display("Comparisons %0d, errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Spacing in cycles between two tick pulses
   task automatic gap(input logic basic, output int k);
      k = 0;
      while ((basic ? bc_tick : sys_tick) !== 1'b1 && k < 400) begin
         @(negedge clk_i);
         k++;
      end
      k = 0;
      do begin
         @(negedge clk_i);
         k++;
      end while ((basic ? bc_tick : sys_tick) !== 1'b1 && k < 400);
   endtask

   // Cycles from the taking edge to the result edge, both counted
   task automatic convert(output int k);
      start = 1'b1;
      k = 0;
      do begin
         @(negedge clk_i);
         k++;
         if (k == 1) begin
            start = 1'b0;
         end
      end while (valid !== 1'b1 && k < 4000);
   endtask

   task automatic do_reset(input logic quiet);
      reset_i = 1'b1;
      settled = quiet;
      repeat (8) @(negedge clk_i);
      check(calib, 1);
      check(mode, 0);
      check({busy, valid, result}, 0);
      reset_i = 1'b0;
   endtask

   task automatic cal_ticks(output int k);
      k = 0;
      while (calib === 1'b1 && k < 20000) begin
         @(negedge clk_i);
         if (bc_tick === 1'b1 && calib === 1'b1) begin
            k++;
         end
      end
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      @(negedge clk_i);
      do_reset(1'b1);
      cal_ticks(n);
      check(n >= 483 && n <= 486, 1);
      foreach (rows[i]) begin
         halve = rows[i].halve;
         dsel = rows[i].dsel;
         imp = rows[i].imp;
         idiv = rows[i].idiv;
         ssel = rows[i].ssel;
         res8 = rows[i].r8;
         pcal = rows[i].pc;
         ain = rows[i].ain;
         d = rows[i].imp ? int'(rows[i].idiv) + 1 : div_tab[rows[i].dsel];
         p = rows[i].halve ? 2 : 1;
         gap(1'b0, n);
         gap(1'b0, n);
         check(n, p);
         gap(1'b1, n);
         gap(1'b1, n);
         check(n, d * p);
         lo = (smp_tab[rows[i].ssel] + (rows[i].r8 ? 32 : 40) + (rows[i].pc ? 12 : 0)) * d * p;
         lo = lo + 6 * p;
         convert(n);
         check(n >= lo && n <= lo + d * p + 3, 1);
         check(result, rows[i].res);
         @(negedge clk_i);
         check({valid, busy}, 0);
      end
      // Back to back: the second start stands in the valid cycle of the first
      {halve, dsel, imp, ssel, res8, pcal} = {1'b0, 2'h1, 1'b0, 2'h0, 1'b0, 1'b0};
      lo = (8 + 40) * 2 + 6;
      convert(n);
      convert(n);
      check(n >= lo - 1 && n <= lo + 5, 1);
      m = 0;
      while (busy !== 1'b0 && m < 4000) begin
         @(negedge clk_i);
         m++;
      end
      check(busy, 0);
      for (int c = 0; c < 4; c++) begin
         src = c[1:0];
         @(negedge clk_i);
         check(mode, c);
      end
      do_reset(1'b0);
      cal_ticks(n);
      check(n >= CAL_SIM - 1 && n <= CAL_SIM + 2, 1);
      // A conversion right after reset must not eat into the idle count
      do_reset(1'b1);
      ain = 12'h12c;
      convert(n);
      check(result, 10'h12c);
      check(calib, 1);
      cal_ticks(m);
      check(m >= 483 && m <= 484, 1);
      complete_run();
   end

   // Whole run is near 7.3k cycles; the limit leaves ample slack
   initial begin
      #500000;
      error_cnt++;
      complete_run();
   end
endmodule
